// ### logic/iubf_regs.sv
// User bias registers, bias adder and two-stage averaging filter
// Functional notes
// - Gyro z offset low and high words form one signed 32-bit bias, reset zero.
// - Accel x offset low and high words form one signed 32-bit bias, reset zero.
// - Accel y offset words combine into a 32-bit bias like the x axis.
// - Accel z offset words combine into a 32-bit bias like the x axis.
// - High word scales like 16-bit output; whole offset like 32-bit output.
// - Filter is two cascaded averagers of 2^B taps; B in bits 2:0, 0 to 6.
// - Filter control readback may show the new value up to 30 us late.
// - Range identifier bits 3:2 give gyro range code; code 10 reserved.
// - Range identifier bits 1:0 always read binary 11.
// - Bias and correction chain runs at 2000 samples per second.
`timescale 1ns/1ps
module iubf_regs
   import iubf_pkg::*;
#(
   parameter int unsigned SAMPLE_DIV = IUBF_SAMPLE_DIV,
   parameter logic [1:0]  GYRO_RANGE = IUBF_RANGE_2000
) (
   input  wire logic        clk,              // 125 MHz system clock
   input  wire logic        nrst,             // Async reset, active low
   input  wire logic [7:0]  avs_address,      // Register index (word address)
   input  wire logic        avs_read,         // Read request
   input  wire logic        avs_write,        // Write request
   input  wire logic [31:0] avs_writedata,    // Write data
   input  wire logic [3:0]  avs_byteenable,   // Byte lanes of a write
   output logic      [31:0] avs_readdata,     // Read data
   output logic             avs_waitrequest,  // Stall of the current request
   input  wire iubf_axes_t  sens_in,          // Factory-corrected samples
   output iubf_out_t        filt_out          // Filtered samples, valid pulse
);

   localparam int unsigned DIVW  = $clog2(SAMPLE_DIV);
   localparam int unsigned SUMW  = 32 + $clog2(IUBF_TAPS_MAX);
   localparam int unsigned PTRW  = $clog2(IUBF_TAPS_MAX);
   localparam int unsigned JOBW  = 3;
   localparam int unsigned MEMAW = JOBW + PTRW;

   generate
      if (SAMPLE_DIV < 32) begin : g_bad_div
         $error("iubf_regs: SAMPLE_DIV too small for one filter pass");
      end
      if (GYRO_RANGE == IUBF_RANGE_BAD) begin : g_bad_range
         $error("iubf_regs: GYRO_RANGE code is reserved");
      end
   endgenerate

   typedef enum logic [2:0] {S_CLR, S_IDLE, S_RD, S_UPD, S_OUT} iubf_seq_t;

   // Saturating signed add
   function automatic iubf_word_t sat_add(input iubf_word_t a, input iubf_word_t b);
      logic signed [32:0] s;
      s = 33'(a) + 33'(b);
      if (s[32] != s[31]) begin
         return s[32] ? 32'sh80000000 : 32'sh7fffffff;
      end
      return s[31:0];
   endfunction

   logic [3:0][15:0]            bias_lo;
   logic [3:0][15:0]            bias_hi;
   iubf_word_t [3:0]            bias;
   logic                        wr_acc;
   logic                        rd_done;
   logic [31:0]                 rd_val;
   logic                        ctrl_wr;
   logic [2:0]                  filt_pend;
   logic [2:0]                  filt_act;
   logic [IUBF_SETTLE_W-1:0]    settle_cnt;
   logic                        apply;
   logic                        flush_req;
   logic [DIVW-1:0]             div_cnt;
   logic                        tick;
   logic [2:0]                  tap_b;
   logic [6:0]                  tap_n;
   iubf_seq_t                   state;
   logic [JOBW-1:0]             job;
   logic [MEMAW-1:0]            clr_addr;
   logic [PTRW-1:0]             wr_ptr;
   iubf_word_t [3:0]            biased;
   iubf_word_t [3:0]            avg0;
   iubf_word_t [3:0]            avg1;
   logic signed [SUMW-1:0]      sums [8];
   iubf_word_t                  job_in;
   logic signed [SUMW-1:0]      next_sum;
   iubf_word_t                  avg_new;
   logic                        mem_we;
   logic [MEMAW-1:0]            mem_waddr;
   logic [31:0]                 mem_wdata;
   logic [MEMAW-1:0]            mem_raddr;
   logic [31:0]                 mem_rdata;

   // ---------------- Avalon-MM slave ----------------
   // Writes complete without wait; reads take one wait cycle so read data
   // can come straight from a flip-flop.
   assign wr_acc          = avs_write && !avs_read;
   assign avs_waitrequest = avs_read && !rd_done;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_done <= 1'b0;
      end else begin
         rd_done <= avs_read && !rd_done;
      end
   end

   always_comb begin
      rd_val = 32'h00000000;
      for (int i = 0; i < IUBF_NUM_AXES; i++) begin
         if (avs_address == IUBF_LOW_OFS[i]) begin
            rd_val = {16'h0000, bias_lo[i]};
         end
         if (avs_address == IUBF_HIGH_OFS[i]) begin
            rd_val = {16'h0000, bias_hi[i]};
         end
      end
      if (avs_address == IUBF_OFS_AVERAGING_FILTER_CONTROL) begin
         rd_val[IUBF_FILT_B_LSB +: IUBF_FILT_B_W] = filt_act;
      end
      if (avs_address == IUBF_OFS_GYRO_RANGE_IDENTIFIER) begin
         rd_val[IUBF_RANGE_LSB +: 2] = GYRO_RANGE;
         rd_val[1:0]                 = IUBF_RANGE_RSVD;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !rd_done) begin
         avs_readdata <= rd_val;
      end
   end

   // ---------------- Offset registers ----------------
   // Only byte lanes 0 and 1 hold bits; lanes 2 and 3 are ignored.
   generate
      for (genvar i = 0; i < IUBF_NUM_AXES; i++) begin : g_axis
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               bias_lo[i] <= IUBF_OFFSET_RST;
               bias_hi[i] <= IUBF_OFFSET_RST;
            end else if (wr_acc) begin
               if (avs_address == IUBF_LOW_OFS[i]) begin
                  if (avs_byteenable[0]) begin
                     bias_lo[i][7:0] <= avs_writedata[7:0];
                  end
                  if (avs_byteenable[1]) begin
                     bias_lo[i][15:8] <= avs_writedata[15:8];
                  end
               end
               if (avs_address == IUBF_HIGH_OFS[i]) begin
                  if (avs_byteenable[0]) begin
                     bias_hi[i][7:0] <= avs_writedata[7:0];
                  end
                  if (avs_byteenable[1]) begin
                     bias_hi[i][15:8] <= avs_writedata[15:8];
                  end
               end
            end
         end
         // High word sits in bits 31:16, so alone it carries 16-bit output scaling
         assign bias[i] = {bias_hi[i], bias_lo[i]};
      end
   endgenerate

   // ---------------- Filter control ----------------
   // A low byte write carries B; a high byte write holds no bits but still
   // counts as an access, so the byte pair of a host sequence restarts the
   // settle timer twice and B takes effect once, after the last byte.
   assign ctrl_wr = wr_acc && (avs_address == IUBF_OFS_AVERAGING_FILTER_CONTROL)
                    && (avs_byteenable[1:0] != 2'b00);
   assign apply   = (settle_cnt == IUBF_SETTLE_W'(1));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         filt_pend <= IUBF_FILT_B_RST;
      end else if (ctrl_wr && avs_byteenable[0]) begin
         filt_pend <= avs_writedata[IUBF_FILT_B_LSB +: IUBF_FILT_B_W];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         settle_cnt <= '0;
      end else if (ctrl_wr) begin
         settle_cnt <= IUBF_SETTLE_W'(IUBF_CTRL_SETTLE_CYC);
      end else if (settle_cnt != '0) begin
         settle_cnt <= settle_cnt - IUBF_SETTLE_W'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         filt_act <= IUBF_FILT_B_RST;
      end else if (apply) begin
         filt_act <= filt_pend;
      end
   end

   // A new tap count invalidates the history, so the filter restarts empty;
   // a new request wins over the clear taken when the flush starts.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flush_req <= 1'b0;
      end else if (apply) begin
         flush_req <= 1'b1;
      end else if (state == S_IDLE) begin
         flush_req <= 1'b0;
      end
   end

   // Out-of-range B saturates to the deepest setting
   assign tap_b = (filt_act > IUBF_FILT_B_MAX) ? IUBF_FILT_B_MAX : filt_act;
   assign tap_n = 7'h01 << tap_b;

   // ---------------- Sample rate divider ----------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt <= '0;
      end else if (tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DIVW'(1);
      end
   end
   assign tick = (div_cnt == DIVW'(SAMPLE_DIV - 1));

   // ---------------- Filter sequencer ----------------
   // Jobs 0..3 run stage one per axis, jobs 4..7 stage two, so stage two
   // always sees the stage one result of the same sample.
   assign job_in   = job[2] ? avg0[job[1:0]] : biased[job[1:0]];
   assign next_sum = sums[job] - SUMW'($signed(mem_rdata)) + SUMW'(job_in);
   assign avg_new  = 32'(next_sum >>> tap_b);

   always_comb begin
      mem_we    = 1'b0;
      mem_waddr = {job, wr_ptr};
      mem_wdata = job_in;
      mem_raddr = {job, wr_ptr - tap_n[PTRW-1:0]};
      case (state)
         S_CLR: begin
            mem_we    = 1'b1;
            mem_waddr = clr_addr;
            mem_wdata = 32'h00000000;
         end
         S_UPD: begin
            mem_we = 1'b1;
         end
         default: begin
            mem_we = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= S_CLR;
         job      <= '0;
         clr_addr <= '0;
      end else begin
         case (state)
            S_CLR: begin
               clr_addr <= clr_addr + MEMAW'(1);
               if (clr_addr == '1) begin
                  state <= S_IDLE;
               end
            end
            S_IDLE: begin
               job <= '0;
               if (flush_req) begin
                  state <= S_CLR;
               end else if (tick) begin
                  state <= S_RD;
               end
            end
            S_RD: begin
               state <= S_UPD;
            end
            S_UPD: begin
               job <= job + JOBW'(1);
               state <= (job == '1) ? S_OUT : S_RD;
            end
            S_OUT: begin
               state <= S_IDLE;
            end
            default: begin
               state <= S_CLR;
            end
         endcase
      end
   end

   // Samples arriving during a flush are dropped
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         biased <= '0;
      end else if (state == S_IDLE && !flush_req && tick) begin
         for (int i = 0; i < IUBF_NUM_AXES; i++) begin
            biased[i] <= sat_add(sens_in.axis[i], bias[i]);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int j = 0; j < 8; j++) begin
            sums[j] <= '0;
         end
      end else if (state == S_CLR) begin
         for (int j = 0; j < 8; j++) begin
            sums[j] <= '0;
         end
      end else if (state == S_UPD) begin
         sums[job] <= next_sum;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avg0 <= '0;
         avg1 <= '0;
      end else if (state == S_UPD) begin
         if (job[2]) begin
            avg1[job[1:0]] <= avg_new;
         end else begin
            avg0[job[1:0]] <= avg_new;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
      end else if (state == S_CLR) begin
         wr_ptr <= '0;
      end else if (state == S_OUT) begin
         wr_ptr <= wr_ptr + PTRW'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         filt_out <= '0;
      end else begin
         filt_out.valid <= (state == S_OUT);
         if (state == S_OUT) begin
            filt_out.axis <= avg1;
         end
      end
   end

   iubf_tap_mem #(
      .WIDTH (32),
      .DEPTH (8 * IUBF_TAPS_MAX)
   ) u_tap_mem (
      .clk   (clk),
      .nrst  (nrst),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

endmodule

// ### logic/iubf_pkg.sv
// Shared constants and types of the user bias and averaging filter block
package iubf_pkg;

   // Clocking and sample rate
   localparam int unsigned IUBF_CLK_HZ          = 125_000_000;
   localparam int unsigned IUBF_SAMPLE_HZ       = 2000;
   localparam int unsigned IUBF_SAMPLE_DIV      = IUBF_CLK_HZ / IUBF_SAMPLE_HZ;

   // Readback settle time of the filter control word (longest time, rounds down)
   localparam int unsigned IUBF_CTRL_SETTLE_US  = 30;
   localparam int unsigned IUBF_CTRL_SETTLE_CYC = IUBF_CTRL_SETTLE_US * (IUBF_CLK_HZ / 1_000_000);
   localparam int unsigned IUBF_SETTLE_W        = $clog2(IUBF_CTRL_SETTLE_CYC + 1);

   // Register indices; the byte address is four times the index
   localparam logic [7:0]  IUBF_OFS_GYRO_Z_OFFSET_LOW         = 8'h48;
   localparam logic [7:0]  IUBF_OFS_GYRO_Z_OFFSET_HIGH        = 8'h4a;
   localparam logic [7:0]  IUBF_OFS_ACCEL_X_OFFSET_LOW        = 8'h4c;
   localparam logic [7:0]  IUBF_OFS_ACCEL_X_OFFSET_HIGH       = 8'h4e;
   localparam logic [7:0]  IUBF_OFS_ACCEL_Y_OFFSET_LOW        = 8'h50;
   localparam logic [7:0]  IUBF_OFS_ACCEL_Y_OFFSET_HIGH       = 8'h52;
   localparam logic [7:0]  IUBF_OFS_ACCEL_Z_OFFSET_LOW        = 8'h54;
   localparam logic [7:0]  IUBF_OFS_ACCEL_Z_OFFSET_HIGH       = 8'h56;
   localparam logic [7:0]  IUBF_OFS_AVERAGING_FILTER_CONTROL  = 8'h5c;
   localparam logic [7:0]  IUBF_OFS_GYRO_RANGE_IDENTIFIER     = 8'h5e;

   // Axis order: 0 gyro z, 1 accel x, 2 accel y, 3 accel z
   localparam int unsigned IUBF_NUM_AXES = 4;
   localparam logic [3:0][7:0] IUBF_LOW_OFS  = {IUBF_OFS_ACCEL_Z_OFFSET_LOW,
                                                IUBF_OFS_ACCEL_Y_OFFSET_LOW,
                                                IUBF_OFS_ACCEL_X_OFFSET_LOW,
                                                IUBF_OFS_GYRO_Z_OFFSET_LOW};
   localparam logic [3:0][7:0] IUBF_HIGH_OFS = {IUBF_OFS_ACCEL_Z_OFFSET_HIGH,
                                                IUBF_OFS_ACCEL_Y_OFFSET_HIGH,
                                                IUBF_OFS_ACCEL_X_OFFSET_HIGH,
                                                IUBF_OFS_GYRO_Z_OFFSET_HIGH};

   // Reset values
   localparam logic [15:0] IUBF_OFFSET_RST    = 16'h0000;
   localparam logic [2:0]  IUBF_FILT_B_RST    = 3'h0;

   // Filter control field
   localparam int unsigned IUBF_FILT_B_LSB    = 0;
   localparam int unsigned IUBF_FILT_B_W      = 3;
   localparam logic [2:0]  IUBF_FILT_B_MAX    = 3'h6;
   localparam int unsigned IUBF_TAPS_MAX      = 64;

   // Range identifier fields and codes
   localparam int unsigned IUBF_RANGE_LSB     = 2;
   localparam logic [1:0]  IUBF_RANGE_RSVD    = 2'h3;
   localparam logic [1:0]  IUBF_RANGE_125     = 2'h0;
   localparam logic [1:0]  IUBF_RANGE_500     = 2'h1;
   localparam logic [1:0]  IUBF_RANGE_BAD     = 2'h2;
   localparam logic [1:0]  IUBF_RANGE_2000    = 2'h3;

   typedef logic signed [31:0] iubf_word_t;

   typedef struct packed {
      iubf_word_t [3:0] axis;
   } iubf_axes_t;

   typedef struct packed {
      logic             valid;
      iubf_word_t [3:0] axis;
   } iubf_out_t;

endpackage

// ### logic/iubf_tap_mem.sv
// Tap history memory of the averaging filter, registered read data
`timescale 1ns/1ps
module iubf_tap_mem #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 512,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,    // System clock
   input  wire logic             nrst,   // Async reset, active low
   input  wire logic             we,     // Write strobe
   input  wire logic [AW-1:0]    waddr,  // Write address
   input  wire logic [WIDTH-1:0] wdata,  // Write data
   input  wire logic [AW-1:0]    raddr,  // Read address
   output logic      [WIDTH-1:0] rdata   // Read data, one cycle after raddr
);

   logic [WIDTH-1:0] mem [DEPTH];

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("iubf_tap_mem: DEPTH must be a power of two");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule

// ### tb/iubf_regs_props.sv
// Checker of register bus handshake and sample output timing
`timescale 1ns/1ps
module iubf_regs_props
   import iubf_pkg::*;
#(
   parameter int unsigned SAMPLE_DIV = IUBF_SAMPLE_DIV,
   parameter logic [1:0]  GYRO_RANGE = IUBF_RANGE_2000
) (
   input wire logic        clk,             // Clock
   input wire logic        nrst,            // Reset, active low
   input wire logic [7:0]  avs_address,     // Index
   input wire logic        avs_read,        // Read
   input wire logic        avs_write,       // Write
   input wire logic [31:0] avs_writedata,   // Write data
   input wire logic [3:0]  avs_byteenable,  // Lanes
   input wire logic [31:0] avs_readdata,    // Read data
   input wire logic        avs_waitrequest, // Stall
   input wire iubf_axes_t  sens_in,         // Samples in
   input wire iubf_out_t   filt_out         // Samples out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   logic [31:0] gap;
   logic        seen;
   // Gap is only judged once a first output has set the tick phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap  <= 32'h0;
         seen <= 1'b0;
      end else if (filt_out.valid) begin
         gap  <= 32'h1;
         seen <= 1'b1;
      end else begin
         gap <= gap + 32'h1;
      end
   end
   sequence s_rd_wait;
      avs_read && avs_waitrequest;
   endsequence
   sequence s_rd_done;
      avs_read && !avs_waitrequest;
   endsequence
   a_write_no_wait: assert property (avs_write && !avs_read |-> !avs_waitrequest)
      else $error("write stalled");
   a_read_one_wait: assert property (s_rd_wait |=> s_rd_done)
      else $error("read not answered after one wait");
   a_read_first_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
      else $error("read answered without wait");
   a_rdata_stands: assert property (!(avs_read && !avs_waitrequest) |-> $stable(avs_readdata))
      else $error("read data moved outside an answer");
   a_range_code: assert property (s_rd_done ##0 avs_address == 8'h5e
      |-> avs_readdata == {28'h0, GYRO_RANGE, IUBF_RANGE_RSVD})
      else $error("range identifier wrong");
   a_unmapped_zero: assert property (s_rd_done ##0 !(avs_address inside {8'h48, 8'h4a,
      8'h4c, 8'h4e, 8'h50, 8'h52, 8'h54, 8'h56, 8'h5c, 8'h5e}) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_unused: assert property (s_rd_done ##0 avs_address == 8'h5c
      |-> avs_readdata[31:3] == 29'h0)
      else $error("filter control unused bits set");
   a_valid_pulse: assert property (filt_out.valid |=> !filt_out.valid)
      else $error("output valid longer than one cycle");
   a_axis_hold: assert property (!filt_out.valid |-> $stable(filt_out.axis))
      else $error("output moved without valid");
   a_sample_rate: assert property (filt_out.valid && seen |-> (gap % SAMPLE_DIV) == 0)
      else $error("output off the sample tick grid");
endmodule

bind iubf_regs iubf_regs_props #(.SAMPLE_DIV(SAMPLE_DIV), .GYRO_RANGE(GYRO_RANGE)) u_props (
   .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sens_in(sens_in),
   .filt_out(filt_out));

// ### tb/iubf_host_model.sv
// Host processor model: bus master of the register interface
`timescale 1ns/1ps
module iubf_host_model (
   input  wire logic        clk,             // Clock
   output logic      [7:0]  avs_address,     // Index
   output logic             avs_read,        // Read
   output logic             avs_write,       // Write
   output logic      [31:0] avs_writedata,   // Write data
   output logic      [3:0]  avs_byteenable,  // Lanes
   input  wire logic [31:0] avs_readdata,    // Read data
   input  wire logic        avs_waitrequest  // Stall
);
   initial begin
      avs_address    = 8'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'h0;
   end
   // Stall and read data are taken at the rising edge, before the slave's own update
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
      avs_address    <= a;
      avs_writedata  <= {16'h0, d};
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read    <= 1'b1;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
endmodule

// ### tb/test_iubf_regs.sv
// Self-checking bench of the user bias registers and averaging filter
`timescale 1ns/1ps
module test_iubf_regs;
   import iubf_pkg::*;
   localparam int unsigned DIV = 64;
   logic        clk;
   logic        nrst;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   iubf_axes_t  sens_in;
   iubf_out_t   filt_out;
   int          err_total;
   int          n_tests;
   int          cyc;
   logic [31:0] rd_v;
   // Axis order gyro z, accel x, accel y, accel z; first and last saturate
   logic [15:0] b_lo [4] = '{16'h0100, 16'hfffe, 16'h0000, 16'hff00};
   logic [15:0] b_hi [4] = '{16'h0000, 16'hffff, 16'h0001, 16'hffff};
   logic [31:0] s_v [4]  = '{32'h7ffffff0, 32'hfffffffb, 32'h0, 32'h80000005};
   logic [31:0] e_v [4]  = '{32'h7fffffff, 32'hfffffff9, 32'h00010000, 32'h80000000};

   iubf_regs #(.SAMPLE_DIV(DIV), .GYRO_RANGE(IUBF_RANGE_500)) dut (
      .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sens_in(sens_in),
      .filt_out(filt_out));
   iubf_host_model u_host (
      .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic end_of_test();
      if (err_total == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_valid();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (filt_out.valid !== 1'b1 && n < 700);
      chk("output valid", {31'h0, filt_out.valid}, 32'h1);
      // Hand back on a rising edge so bus calls may follow at once
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         err_total++;
         end_of_test();
      end
   end

   initial begin
      nrst      = 1'b0;
      sens_in   = '0;
      err_total = 0;
      n_tests   = 0;
      cyc       = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         u_host.rd(IUBF_LOW_OFS[i], rd_v);
         chk("offset low reset", rd_v, 32'h0);
         u_host.rd(IUBF_HIGH_OFS[i], rd_v);
         chk("offset high reset", rd_v, 32'h0);
      end
      u_host.rd(IUBF_OFS_AVERAGING_FILTER_CONTROL, rd_v);
      chk("filter control reset", rd_v, 32'h0);
      // Read-only place must ignore a write
      u_host.wr(IUBF_OFS_GYRO_RANGE_IDENTIFIER, 16'h0000, 4'b0011);
      u_host.rd(IUBF_OFS_GYRO_RANGE_IDENTIFIER, rd_v);
      chk("range identifier", rd_v, {28'h0, IUBF_RANGE_500, 2'b11});
      u_host.wr(8'h40, 16'h1234, 4'b0011);
      u_host.rd(8'h40, rd_v);
      chk("unmapped read", rd_v, 32'h0);
      u_host.wr(IUBF_OFS_GYRO_Z_OFFSET_LOW, 16'h1234, 4'b0011);
      u_host.wr(IUBF_OFS_GYRO_Z_OFFSET_LOW, 16'hab00, 4'b0010);
      u_host.rd(IUBF_OFS_GYRO_Z_OFFSET_LOW, rd_v);
      chk("byte lane write", rd_v, 32'h0000ab34);
      for (int i = 0; i < 4; i++) begin
         u_host.wr(IUBF_LOW_OFS[i], b_lo[i], 4'b0011);
         u_host.wr(IUBF_HIGH_OFS[i], b_hi[i], 4'b0011);
         u_host.rd(IUBF_LOW_OFS[i], rd_v);
         chk("offset low", rd_v, {16'h0, b_lo[i]});
         u_host.rd(IUBF_HIGH_OFS[i], rd_v);
         chk("offset high", rd_v, {16'h0, b_hi[i]});
         sens_in.axis[i] <= s_v[i];
      end
      // First output already follows the writes, as the reset clear outlasts them
      wait_valid();
      wait_valid();
      for (int i = 0; i < 4; i++) begin
         chk("biased sample", filt_out.axis[i], e_v[i]);
      end
      u_host.wr(IUBF_OFS_AVERAGING_FILTER_CONTROL, 16'h0004, 4'b0001);
      u_host.wr(IUBF_OFS_AVERAGING_FILTER_CONTROL, 16'h0000, 4'b0010);
      u_host.rd(IUBF_OFS_AVERAGING_FILTER_CONTROL, rd_v);
      chk("control before settle", rd_v, 32'h0);
      repeat (IUBF_CTRL_SETTLE_CYC) @(posedge clk);
      u_host.rd(IUBF_OFS_AVERAGING_FILTER_CONTROL, rd_v);
      chk("control after settle", rd_v, 32'h4);
      // Outlast outputs in flight and the flush, but not the first fresh sample
      repeat (515) @(posedge clk);
      wait_valid();
      chk("first of 16 taps", filt_out.axis[2], 32'h00000100);
      repeat (31) wait_valid();
      chk("settled average", filt_out.axis[2], 32'h00010000);
      end_of_test();
   end
endmodule
